// File: pmft_defines.svh
`ifndef PMFT_DEFINES_SVH
`define PMFT_DEFINES_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define PMFT_ADDR_PIN7_CTL   8'h17
`define PMFT_ADDR_TRIG_CTL   8'h18
`define PMFT_ADDR_HIGH_HI    8'h19
`define PMFT_ADDR_HIGH_LO    8'h1A

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define PMFT_SEL_MSB         7
`define PMFT_SEL_LSB         5
`define PMFT_SRC_MSB         4
`define PMFT_SRC_LSB         2
`define PMFT_VAL_BIT         1
`define PMFT_EN_BIT          0
`define PMFT_MODE_MSB        7
`define PMFT_MODE_LSB        4
`define PMFT_ONE_SHOT_BIT    3
`define PMFT_GEN_ON_BIT      0
`define PMFT_EXT_LAST_PIN    3'h6

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define PMFT_RST_PIN7_CTL    8'h00
`define PMFT_RST_MODE        4'h0
`define PMFT_RST_GEN_ON      1'b0
`define PMFT_RST_HIGH        16'h0000
`define PMFT_RST_LOW         16'h0001

// ------------------------------------------------------------
// Timing: 25 MHz reference tick derived from the 200 MHz clock
// ------------------------------------------------------------
`define PMFT_CLK_MHZ         200
`define PMFT_REF_MHZ         25
`define PMFT_REF_DIV         (`PMFT_CLK_MHZ / `PMFT_REF_MHZ)

`endif

// File: pmft_pkg.sv
package pmft_pkg;

  // ----------------------------------------------------------
  // Output source codes
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    PMFT_SRC_RX0  = 3'h0,
    PMFT_SRC_RX1  = 3'h1,
    PMFT_SRC_RX2  = 3'h2,
    PMFT_SRC_RX3  = 3'h3,
    PMFT_SRC_DEV  = 3'h4,
    PMFT_SRC_RSVD = 3'h5,
    PMFT_SRC_TX0  = 3'h6,
    PMFT_SRC_TX1  = 3'h7
  } pmft_src_e;

  // ----------------------------------------------------------
  // Device status select codes
  // ----------------------------------------------------------
  typedef enum logic [2:0] {
    PMFT_DS_VAL      = 3'h0,
    PMFT_DS_LOCK_OR  = 3'h1,
    PMFT_DS_LOCK_AND = 3'h2,
    PMFT_DS_PASS_AND = 3'h3,
    PMFT_DS_RSVD4    = 3'h4,
    PMFT_DS_TRIG     = 3'h5,
    PMFT_DS_RSVD6    = 3'h6,
    PMFT_DS_RSVD7    = 3'h7
  } pmft_ds_sel_e;

  // ----------------------------------------------------------
  // Pulse generator states
  // ----------------------------------------------------------
  typedef enum logic [1:0] {
    PMFT_GEN_IDLE = 2'b00,
    PMFT_GEN_HIGH = 2'b01,
    PMFT_GEN_LOW  = 2'b10
  } pmft_gen_e;

  typedef struct packed {
    pmft_gen_e   state;
    logic [15:0] cnt;
    logic        pulse;
    logic        pend;
  } pmft_gen_s;

  typedef struct packed {
    logic [7:0]  pin_ctl;
    logic [3:0]  mode;
    logic        gen_on;
    logic [15:0] high_period;
    logic        one_shot;
    logic [2:0]  ref_cnt;
    logic        ref_tick;
    logic        trig;
    logic        pin_out;
    logic        pin_oe;
    logic [7:0]  rdata;
  } pmft_top_s;

endpackage : pmft_pkg

// File: pmft_trig_if.sv
`timescale 1ns/1ps

// Control and result of the trigger pulse generator
interface pmft_trig_if;
  logic        tick;
  logic        run;
  logic        gen_on;
  logic        one_shot;
  logic [15:0] high_period;
  logic        pulse;

  modport ctl (output tick, output run, output gen_on, output one_shot,
               output high_period, input pulse);
  modport gen (input tick, input run, input gen_on, input one_shot,
               input high_period, output pulse);
endinterface : pmft_trig_if

// File: pmft_trig_gen.sv
`timescale 1ns/1ps
`include "pmft_defines.svh"

module pmft_trig_gen #(
  parameter logic [15:0] LOW_PERIOD = `PMFT_RST_LOW
) (
  input  wire logic  clk,
  input  wire logic  rst_b,
  pmft_trig_if.gen   tif
);

  pmft_pkg::pmft_gen_s r_reg;
  pmft_pkg::pmft_gen_s r_next;
  logic                start;

  // ----------------------------------------------------------
  // Next state: counts ticks of the selected time base
  // ----------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    start  = tif.tick && (tif.gen_on || r_reg.pend);
    unique case (r_reg.state)
      pmft_pkg::PMFT_GEN_IDLE: begin
        if (start) begin
          r_next.state = pmft_pkg::PMFT_GEN_HIGH;
          r_next.cnt   = 16'h0000;
          r_next.pulse = 1'b1;
        end
      end
      pmft_pkg::PMFT_GEN_HIGH: begin
        if (tif.tick) begin
          // High lasts programmed value plus one tick
          if (r_reg.cnt == tif.high_period) begin
            r_next.cnt   = 16'h0000;
            r_next.pulse = 1'b0;
            r_next.state = tif.gen_on ? pmft_pkg::PMFT_GEN_LOW
                                      : pmft_pkg::PMFT_GEN_IDLE;
          end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
          end
        end
      end
      pmft_pkg::PMFT_GEN_LOW: begin
        if (!tif.gen_on) begin
          r_next.state = pmft_pkg::PMFT_GEN_IDLE;
        end else if (tif.tick) begin
          if (r_reg.cnt == LOW_PERIOD) begin
            r_next.cnt   = 16'h0000;
            r_next.pulse = 1'b1;
            r_next.state = pmft_pkg::PMFT_GEN_HIGH;
          end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
          end
        end
      end
      default: begin
        r_next.state = pmft_pkg::PMFT_GEN_IDLE;
        r_next.pulse = 1'b0;
      end
    endcase
    // A request arriving as the pending one starts is kept
    r_next.pend = (r_reg.pend && !(start &&
                   r_reg.state == pmft_pkg::PMFT_GEN_IDLE))
                  || tif.one_shot;
    // Leaving internal mode drops any pulse in flight
    if (!tif.run) begin
      r_next.state = pmft_pkg::PMFT_GEN_IDLE;
      r_next.pulse = 1'b0;
      r_next.pend  = 1'b0;
      r_next.cnt   = 16'h0000;
    end
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '{state: pmft_pkg::PMFT_GEN_IDLE, cnt: 16'h0000,
                 pulse: 1'b0, pend: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign tif.pulse = r_reg.pulse;

endmodule : pmft_trig_gen

// File: pmft_pin7_mux.sv
// Operation
// - Source field picks rx, status or tx
// - Rx source: remote pins, lock, pass, valids
// - Status: local value, lock or/and, pass and
// - Status code 101 routes the trigger pulse
// - Tx source: pass and/or, frame, line
// - Tx source: synchronized, interrupt, 110-111 reserved
// - Enabled pin drives local value when chosen
// - Drive enable gates driver; fields reset zero
// - Modes 0000-0011 time from port frame clock
// - Modes 01xx time from 25 MHz reference
// - Modes 1000-1100 take trigger from pins 0-4
// - 1110 pin 6; 1101 pin 5, 1111 pin 6
// - One-shot write gives one pulse, reads zero
// - Bit 0 turns periodic generation on
// - High time lasts programmed value plus one
`timescale 1ns/1ps
`include "pmft_defines.svh"

module pmft_pin7_mux #(
  parameter logic [15:0] LOW_PERIOD = `PMFT_RST_LOW
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic [15:0] rx_remote_pin,
  input  wire logic [3:0]  rx_port_en,
  input  wire logic [3:0]  rx_lock,
  input  wire logic [3:0]  rx_pass,
  input  wire logic [3:0]  rx_frame_valid,
  input  wire logic [3:0]  rx_line_valid,
  input  wire logic [3:0]  rx_frame_tick,
  input  wire logic [1:0]  tx_pass_and,
  input  wire logic [1:0]  tx_pass_or,
  input  wire logic [1:0]  tx_frame_valid,
  input  wire logic [1:0]  tx_line_valid,
  input  wire logic [1:0]  tx_synchronized,
  input  wire logic [1:0]  tx_interrupt,
  input  wire logic [6:0]  ext_pin,
  output logic             pin7_out,
  output logic             pin7_oe,
  output logic             camera_trigger_pulse
);

  pmft_pkg::pmft_top_s r_reg;
  pmft_pkg::pmft_top_s r_next;
  pmft_trig_if         tif ();

  logic [2:0]  pin7_output_select;
  logic [2:0]  pin7_output_source;
  logic        pin7_local_value;
  logic        pin7_drive_enable;
  logic        internal_mode;
  logic [2:0]  ext_idx;
  logic        ext_level;
  logic        rx_bit;
  logic        dev_bit;
  logic        tx_bit;
  logic        mux_bit;
  logic [1:0]  rx_idx;
  logic        tx_idx;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  // AND over enabled ports; no enabled port reads as 0 so a
  // disabled hub never reports all-locked
  function automatic logic and_enabled(input logic [3:0] v,
                                       input logic [3:0] en);
    and_enabled = (|en) && (&(v | ~en));
  endfunction : and_enabled

  function automatic logic [2:0] ctl_field(input logic [7:0] c,
                                           input int msb);
    ctl_field = c[msb -: 3];
  endfunction : ctl_field

  // ----------------------------------------------------------
  // Field views of the pin control register
  // ----------------------------------------------------------
  assign pin7_output_select = ctl_field(r_reg.pin_ctl, `PMFT_SEL_MSB);
  assign pin7_output_source = ctl_field(r_reg.pin_ctl, `PMFT_SRC_MSB);
  assign pin7_local_value   = r_reg.pin_ctl[`PMFT_VAL_BIT];
  assign pin7_drive_enable  = r_reg.pin_ctl[`PMFT_EN_BIT];
  assign rx_idx             = pin7_output_source[1:0];
  assign tx_idx             = pin7_output_source[0];

  // ----------------------------------------------------------
  // Trigger source decode
  // ----------------------------------------------------------
  assign internal_mode = ~r_reg.mode[3];
  // Code 111 saturates at pin 6 (101 is pin 5, 110 is pin 6)
  assign ext_idx = (r_reg.mode[2:0] > `PMFT_EXT_LAST_PIN)
                   ? `PMFT_EXT_LAST_PIN : r_reg.mode[2:0];
  assign ext_level = ext_pin[ext_idx];

  // Time base: port frame clock or the 25 MHz reference
  assign tif.tick = r_reg.mode[2] ? r_reg.ref_tick
                                  : rx_frame_tick[r_reg.mode[1:0]];
  assign tif.run         = internal_mode;
  assign tif.gen_on      = r_reg.gen_on;
  assign tif.one_shot    = r_reg.one_shot;
  assign tif.high_period = r_reg.high_period;

  pmft_trig_gen #(
    .LOW_PERIOD (LOW_PERIOD)
  ) u_gen (
    .clk   (clk),
    .rst_b (rst_b),
    .tif   (tif.gen)
  );

  // ----------------------------------------------------------
  // Output source multiplexer
  // ----------------------------------------------------------
  always_comb begin
    unique case (pin7_output_select)
      3'h0, 3'h1, 3'h2, 3'h3:
        rx_bit = rx_remote_pin[{rx_idx, pin7_output_select[1:0]}];
      3'h4:    rx_bit = rx_lock[rx_idx];
      3'h5:    rx_bit = rx_pass[rx_idx];
      3'h6:    rx_bit = rx_frame_valid[rx_idx];
      default: rx_bit = rx_line_valid[rx_idx];
    endcase
  end

  always_comb begin
    unique case (pmft_pkg::pmft_ds_sel_e'(pin7_output_select))
      pmft_pkg::PMFT_DS_VAL:      dev_bit = pin7_local_value;
      pmft_pkg::PMFT_DS_LOCK_OR:  dev_bit = |(rx_lock & rx_port_en);
      pmft_pkg::PMFT_DS_LOCK_AND:
        dev_bit = and_enabled(rx_lock, rx_port_en);
      pmft_pkg::PMFT_DS_PASS_AND:
        dev_bit = and_enabled(rx_pass, rx_port_en);
      pmft_pkg::PMFT_DS_TRIG:     dev_bit = r_reg.trig;
      default:                    dev_bit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (pin7_output_select)
      3'h0:    tx_bit = tx_pass_and[tx_idx];
      3'h1:    tx_bit = tx_pass_or[tx_idx];
      3'h2:    tx_bit = tx_frame_valid[tx_idx];
      3'h3:    tx_bit = tx_line_valid[tx_idx];
      3'h4:    tx_bit = tx_synchronized[tx_idx];
      3'h5:    tx_bit = tx_interrupt[tx_idx];
      default: tx_bit = 1'b0;
    endcase
  end

  always_comb begin
    unique case (pmft_pkg::pmft_src_e'(pin7_output_source))
      pmft_pkg::PMFT_SRC_RX0, pmft_pkg::PMFT_SRC_RX1,
      pmft_pkg::PMFT_SRC_RX2, pmft_pkg::PMFT_SRC_RX3:
        mux_bit = rx_bit;
      pmft_pkg::PMFT_SRC_DEV:  mux_bit = dev_bit;
      pmft_pkg::PMFT_SRC_TX0,
      pmft_pkg::PMFT_SRC_TX1:  mux_bit = tx_bit;
      default:                 mux_bit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------
  // Next state: registers, divider, trigger and pin drive
  // ----------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.one_shot = 1'b0;
    r_next.rdata    = 8'h00;

    // Divide by eight for the 25 MHz reference enable
    if (r_reg.ref_cnt == 3'(`PMFT_REF_DIV - 1)) begin
      r_next.ref_cnt  = 3'h0;
      r_next.ref_tick = 1'b1;
    end else begin
      r_next.ref_cnt  = r_reg.ref_cnt + 3'h1;
      r_next.ref_tick = 1'b0;
    end

    // Register writes; unmapped offsets are ignored
    if (reg_wr) begin
      unique case (reg_addr)
        `PMFT_ADDR_PIN7_CTL: r_next.pin_ctl = reg_wdata;
        `PMFT_ADDR_TRIG_CTL: begin
          r_next.mode = reg_wdata[`PMFT_MODE_MSB:`PMFT_MODE_LSB];
          r_next.gen_on   = reg_wdata[`PMFT_GEN_ON_BIT];
          r_next.one_shot = reg_wdata[`PMFT_ONE_SHOT_BIT];
        end
        `PMFT_ADDR_HIGH_HI: r_next.high_period[15:8] = reg_wdata;
        `PMFT_ADDR_HIGH_LO: r_next.high_period[7:0]  = reg_wdata;
        default: ;
      endcase
    end

    // Register reads, one cycle late; one-shot bit reads 0
    if (reg_rd) begin
      unique case (reg_addr)
        `PMFT_ADDR_PIN7_CTL: r_next.rdata = r_reg.pin_ctl;
        `PMFT_ADDR_TRIG_CTL:
          r_next.rdata = {r_reg.mode, 3'h0, r_reg.gen_on};
        `PMFT_ADDR_HIGH_HI: r_next.rdata = r_reg.high_period[15:8];
        `PMFT_ADDR_HIGH_LO: r_next.rdata = r_reg.high_period[7:0];
        default:            r_next.rdata = 8'h00;
      endcase
    end

    // Trigger is generated or follows the chosen pin
    r_next.trig = internal_mode ? tif.pulse : ext_level;

    // Driver gated by enable, low and off when disabled
    r_next.pin_oe  = pin7_drive_enable;
    r_next.pin_out = pin7_drive_enable && mux_bit;
  end

  // ----------------------------------------------------------
  // State register
  // ----------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r_reg <= '{pin_ctl: `PMFT_RST_PIN7_CTL, mode: `PMFT_RST_MODE,
                 gen_on: `PMFT_RST_GEN_ON, high_period: `PMFT_RST_HIGH,
                 one_shot: 1'b0, ref_cnt: 3'h0, ref_tick: 1'b0,
                 trig: 1'b0, pin_out: 1'b0, pin_oe: 1'b0,
                 rdata: 8'h00};
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata            = r_reg.rdata;
  assign pin7_out             = r_reg.pin_out;
  assign pin7_oe              = r_reg.pin_oe;
  assign camera_trigger_pulse = r_reg.trig;

endmodule : pmft_pin7_mux

// File: pmft_pin7_checker.sv
`timescale 1ns/1ps
`include "pmft_defines.svh"

// ----------------------------------------------------------
// Port checks for the pin 7 mux and trigger control
// ----------------------------------------------------------
module pmft_pin7_checker #(
  parameter logic [15:0] LOW_PERIOD = 16'h0001
) (
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [6:0] ext_pin,
  input wire logic       pin7_out,
  input wire logic       pin7_oe,
  input wire logic       camera_trigger_pulse
);
  logic [7:0] ctl_reg;
  logic [3:0] mode_reg;
  logic [2:0] ext_idx;
  logic       wr_ctl;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Shadow of the control fields, updated on the same edge as the design
  assign wr_ctl = reg_wr && reg_addr == `PMFT_ADDR_PIN7_CTL;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctl_reg  <= 8'h00;
      mode_reg <= 4'h0;
    end else begin
      if (wr_ctl) ctl_reg <= reg_wdata;
      if (reg_wr && reg_addr == `PMFT_ADDR_TRIG_CTL) mode_reg <= reg_wdata[7:4];
    end
  end

  // External pin per mode; 1101 taken as pin 5 since the table omits it
  assign ext_idx = (mode_reg < 4'hD) ? mode_reg[2:0] :
                   ((mode_reg == 4'hD) ? 3'h5 : 3'h6);

  rst_vals_a: assert property (
    disable iff (1'h0) !rst_b |=> !pin7_oe && !pin7_out &&
      !camera_trigger_pulse && reg_rdata == 8'h00)
    else $error("outputs not cleared by reset");
  oe_gated_a: assert property (!pin7_oe |-> !pin7_out)
    else $error("pin data while driver is off");
  oe_follows_a: assert property (
    wr_ctl ##1 !wr_ctl |=> pin7_oe == $past(reg_wdata[0], 2))
    else $error("drive enable does not follow write");
  ctl_readback_a: assert property (
    wr_ctl ##1 !reg_wr ##1
    (reg_rd && !reg_wr && reg_addr == `PMFT_ADDR_PIN7_CTL)
    |=> reg_rdata == $past(reg_wdata, 3))
    else $error("pin control reads back wrong");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without a read");
  unmapped_zero_a: assert property (
    reg_rd && (reg_addr < 8'h17 || reg_addr > 8'h1A) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  one_shot_zero_a: assert property (
    reg_rd && reg_addr == `PMFT_ADDR_TRIG_CTL |=> reg_rdata[3:1] == 3'h0)
    else $error("one-shot bit reads nonzero");
  local_val_a: assert property (
    ctl_reg[7:2] == 6'h04 && ctl_reg[0] |=> pin7_out == $past(ctl_reg[1]))
    else $error("pin does not show local value");
  trig_on_pin_a: assert property (
    ctl_reg[7:2] == 6'h2C && ctl_reg[0]
    |=> pin7_out == $past(camera_trigger_pulse))
    else $error("pin does not show trigger");
  ext_follow_a: assert property (
    mode_reg[3] |=> camera_trigger_pulse == $past(ext_pin[ext_idx]))
    else $error("trigger does not follow external pin");

  cover property (reg_wr && reg_addr == `PMFT_ADDR_TRIG_CTL && reg_wdata[3]);
  cover property (pin7_oe && pin7_out);
  cover property ($rose(camera_trigger_pulse) && !mode_reg[3]);
endmodule : pmft_pin7_checker

bind pmft_pin7_mux pmft_pin7_checker #(.LOW_PERIOD(LOW_PERIOD)) u_chk (
  .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .ext_pin(ext_pin), .pin7_out(pin7_out), .pin7_oe(pin7_oe),
  .camera_trigger_pulse(camera_trigger_pulse));

// File: pmft_pin7_partner.sv
`timescale 1ns/1ps

// Camera side of pin 7 and of the external trigger pins
module pmft_pin7_partner (
  input  wire logic       pin7_out,
  input  wire logic       pin7_oe,
  input  wire logic [6:0] ext_drive,
  output logic            pin_level,
  output logic [6:0]      ext_pin
);
  // Camera input has a pull-down, so a released pin reads low
  assign pin_level = pin7_oe ? pin7_out : 1'h0;
  // Camera strobes reach the trigger pins as driven
  assign ext_pin = ext_drive;
endmodule : pmft_pin7_partner

// File: pmft_pin7_mux_bench.sv
`timescale 1ns/1ps
`include "pmft_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end

// ----------------------------------------------------------
// Self-checking bench: drivers note, monitor compares
// ----------------------------------------------------------
module pmft_pin7_mux_bench;
  localparam logic [15:0] LOWP = 16'h0001;
  localparam int          TICK = `PMFT_REF_DIV;
  typedef struct packed {
    logic [2:0]  kind;
    logic [15:0] val;
  } pmft_note_s;
  logic        clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [15:0] rx_remote_pin = 16'h0000, seed = 16'h0011, got, v;
  logic [3:0]  rx_port_en = 4'h0, rx_lock = 4'h0, rx_pass = 4'h0;
  logic [3:0]  rx_frame_valid = 4'h0, rx_line_valid = 4'h0;
  logic [3:0]  rx_frame_tick = 4'h0;
  logic [1:0]  tx_pass_and = 2'h0, tx_pass_or = 2'h0, tx_frame_valid = 2'h0;
  logic [1:0]  tx_line_valid = 2'h0, tx_synchronized = 2'h0;
  logic [1:0]  tx_interrupt = 2'h0;
  logic [6:0]  ext_drive = 7'h00, ext_pin;
  logic        pin7_out, pin7_oe, trig, pin_level, look = 1'h0;
  logic [47:0] r;
  pmft_note_s  notes[$], nt;
  string       kind_nm[5] = '{"reg_rdata", "pin7", "pin7_oe", "trigger", "pulse"};
  int          error_cnt = 0, n_tests = 0, meas, rises, hi_len, lo_len;
  int          tick_port = 0, tick_cnt = 0;

  pmft_pin7_mux #(.LOW_PERIOD(LOWP)) dut (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .rx_remote_pin(rx_remote_pin), .rx_port_en(rx_port_en),
    .rx_lock(rx_lock), .rx_pass(rx_pass), .rx_frame_valid(rx_frame_valid),
    .rx_line_valid(rx_line_valid), .rx_frame_tick(rx_frame_tick),
    .tx_pass_and(tx_pass_and), .tx_pass_or(tx_pass_or),
    .tx_frame_valid(tx_frame_valid), .tx_line_valid(tx_line_valid),
    .tx_synchronized(tx_synchronized), .tx_interrupt(tx_interrupt),
    .ext_pin(ext_pin), .pin7_out(pin7_out), .pin7_oe(pin7_oe),
    .camera_trigger_pulse(trig));
  pmft_pin7_partner cam (.pin7_out(pin7_out), .pin7_oe(pin7_oe),
    .ext_drive(ext_drive), .pin_level(pin_level), .ext_pin(ext_pin));

  // Clock generator
  always #2.5 clk = ~clk;

  // Frame ticks: chosen port every 10 cycles, others on a clashing rhythm
  always @(negedge clk) begin
    tick_cnt <= (tick_cnt == 9) ? 0 : tick_cnt + 1;
    rx_frame_tick <= ((4'h1 << tick_port) & {4{tick_cnt == 0}}) |
                     (~(4'h1 << tick_port) & {4{tick_cnt % 3 == 1}});
  end

  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction : rnd

  // Reference pin value; status 101 is the trigger, idle in this phase
  function automatic logic exp_pin(input logic [2:0] sel, src,
                                   input logic val);
    logic [3:0] rxv;
    logic [5:0] txv;
    rxv = {rx_line_valid[src[1:0]], rx_frame_valid[src[1:0]],
           rx_pass[src[1:0]], rx_lock[src[1:0]]};
    txv = {tx_interrupt[src[0]], tx_synchronized[src[0]],
           tx_line_valid[src[0]], tx_frame_valid[src[0]],
           tx_pass_or[src[0]], tx_pass_and[src[0]]};
    if (!src[2]) return sel[2] ? rxv[sel[1:0]] : rx_remote_pin[{src[1:0], sel[1:0]}];
    if (src[1]) return (sel < 3'h6) ? txv[sel] : 1'h0;
    if (src[0]) return 1'h0;
    case (sel)
      3'h0: return val;
      3'h1: return |(rx_lock & rx_port_en);
      3'h2: return (rx_port_en != 4'h0) && &(rx_lock | ~rx_port_en);
      3'h3: return (rx_port_en != 4'h0) && &(rx_pass | ~rx_port_en);
      default: return 1'h0;
    endcase
  endfunction : exp_pin

  task automatic note(input logic [2:0] k, input logic [15:0] e);
    notes.push_back('{k, e});
    look = 1'h1;
    @(negedge clk);
    look = 1'h0;
  endtask : note

  // Idle cycle after each write so back-to-back calls never
  // drop and raise the strobe in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge clk);
    reg_wr = 1'h0;
    @(negedge clk);
  endtask : wr

  // Read data stands only the cycle after the strobe, so note it then
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge clk);
    reg_rd = 1'h0;
    note(3'h0, {8'h00, e});
  endtask : rd

  // Count rises, first high length and the low after it
  task automatic watch(input int n);
    logic last;
    rises = 0;
    hi_len = 0;
    lo_len = 0;
    last = trig;
    repeat (n) begin
      @(negedge clk);
      if (trig && !last) rises++;
      if (trig && rises == 1) hi_len++;
      if (!trig && rises == 1 && hi_len > 0) lo_len++;
      last = trig;
    end
  endtask : watch

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // Monitor: takes the oldest note when a result is flagged
  always @(negedge clk) begin
    #1;
    if (look) begin
      nt = notes.pop_front();
      case (nt.kind)
        3'h0: got = {8'h00, reg_rdata};
        3'h1: got = {15'h0000, pin_level};
        3'h2: got = {15'h0000, pin7_oe};
        3'h3: got = {15'h0000, trig};
        default: got = meas[15:0];
      endcase
      `CHK(kind_nm[nt.kind], nt.val, got)
    end
  end

  // Watchdog well beyond the roughly 1200 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'h1;
    @(negedge clk);
    for (int a = 8'h17; a < 8'h1B; a++) rd(a[7:0], 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    v = rnd();
    wr(`PMFT_ADDR_HIGH_HI, v[7:0]);
    rd(`PMFT_ADDR_HIGH_HI, v[7:0]);
    wr(`PMFT_ADDR_TRIG_CTL, 8'hFF);
    rd(`PMFT_ADDR_TRIG_CTL, 8'hF1);
    wr(`PMFT_ADDR_HIGH_HI, 8'h00);
    $display("register test done");
    for (int m = 8; m < 16; m++) begin
      v = rnd();
      ext_drive = v[6:0];
      wr(`PMFT_ADDR_TRIG_CTL, {m[3:0], 4'h0});
      repeat (2) @(negedge clk);
      note(3'h3, 16'(ext_drive[m < 13 ? m - 8 : (m == 13 ? 5 : 6)]));
    end
    wr(`PMFT_ADDR_TRIG_CTL, 8'h00);
    $display("external trigger test done");
    for (int i = 0; i < 64; i++) begin
      r = {rnd(), rnd(), rnd()};
      {rx_remote_pin, rx_port_en, rx_lock, rx_pass, rx_frame_valid,
       rx_line_valid, tx_pass_and, tx_pass_or, tx_frame_valid,
       tx_line_valid, tx_synchronized, tx_interrupt} = r;
      wr(`PMFT_ADDR_PIN7_CTL, {i[5:0], r[0], 1'h1});
      repeat (2) @(negedge clk);
      note(3'h1, 16'(exp_pin(i[5:3], i[2:0], r[0])));
    end
    wr(`PMFT_ADDR_PIN7_CTL, 8'h12);
    rd(`PMFT_ADDR_PIN7_CTL, 8'h12);
    repeat (2) @(negedge clk);
    note(3'h1, 16'h0000);
    note(3'h2, 16'h0000);
    wr(`PMFT_ADDR_PIN7_CTL, 8'h13);
    repeat (2) @(negedge clk);
    note(3'h1, 16'h0001);
    note(3'h2, 16'h0001);
    $display("pin mux test done");
    // One-shot per port clock; generator off, one pulse at a time
    for (int p = 0; p < 4; p++) begin
      tick_port = p;
      wr(`PMFT_ADDR_TRIG_CTL, {2'h0, p[1:0], 4'h8});
      watch(60);
      meas = hi_len;
      note(3'h4, 16'h000A);
    end
    wr(`PMFT_ADDR_HIGH_LO, 8'h02);
    wr(`PMFT_ADDR_TRIG_CTL, 8'h58);
    watch(300);
    meas = hi_len;
    note(3'h4, 16'(3 * TICK));
    meas = rises;
    note(3'h4, 16'h0001);
    rd(`PMFT_ADDR_TRIG_CTL, 8'h50);
    $display("one-shot test done");
    wr(`PMFT_ADDR_HIGH_LO, 8'h00);
    wr(`PMFT_ADDR_PIN7_CTL, 8'hB1);
    wr(`PMFT_ADDR_TRIG_CTL, 8'h41);
    watch(120);
    meas = hi_len;
    note(3'h4, 16'(TICK));
    meas = lo_len;
    note(3'h4, 16'(TICK * (LOWP + 1)));
    wr(`PMFT_ADDR_TRIG_CTL, 8'h40);
    watch(80);
    meas = rises;
    note(3'h4, 16'h0000);
    $display("continuous test done");
    final_report();
  end
endmodule : pmft_pin7_mux_bench
